// ---- design/pcs_pkg.sv ----
// Package with register map, field layout and reset values of the clock select / error inject registers
// Function
// - Divider bit picks divide-by-2 or divide-by-4 output
// - Eight-bit counter of self-test back-channel CRC errors
// - Force bit injects exactly one forward error
// - Self-test field N injects N errors
// - Status bit shows strap chose external oscillator
// - External-lock bit selects external clock as PLL source under override while internal-oscillator bit is clear
// - Internal-oscillator bit feeds oscillator to PLL under override; reset one
package pcs_pkg;

  localparam int unsigned PCS_AW = 8;
  localparam int unsigned PCS_DW = 8;

  localparam logic [7:0] PCS_OFF_OSC_DIV  = 8'h29;
  localparam logic [7:0] PCS_OFF_CRC_CNT  = 8'h2a;
  localparam logic [7:0] PCS_OFF_FWD_INJ  = 8'h2d;
  localparam logic [7:0] PCS_OFF_PLL_OVR  = 8'h35;

  localparam int unsigned PCS_BIT_OSC_DIV   = 5;
  localparam int unsigned PCS_BIT_FORCE_ONE = 7;
  localparam int unsigned PCS_BIT_STRAP     = 3;
  localparam int unsigned PCS_BIT_EXT_LOCK  = 1;
  localparam int unsigned PCS_BIT_INT_OSC   = 0;

  localparam logic [1:0] PCS_RST_OSC_RSVD_HI = 2'h0;
  localparam logic [4:0] PCS_RST_OSC_RSVD_LO = 5'h06;
  localparam logic       PCS_RST_OSC_DIV     = 1'b0;
  localparam logic [7:0] PCS_RST_CRC_CNT     = 8'h00;
  localparam logic [6:0] PCS_RST_ST_ERRS     = 7'h00;
  localparam logic [3:0] PCS_RST_OVR_RSVD    = 4'h0;
  localparam logic       PCS_RST_EXT_LOCK    = 1'b0;
  localparam logic       PCS_RST_INT_OSC     = 1'b1;

  localparam logic [7:0] PCS_CRC_CNT_MAX = 8'hff;

  typedef enum logic [1:0] {
    PCS_SRC_PCLK = 2'h0,
    PCS_SRC_OSC  = 2'h1,
    PCS_SRC_EXT  = 2'h3
  } pcs_src_e;

  typedef struct packed {
    logic         wr;
    logic         rd;
    logic [7:0]   addr;
    logic [7:0]   wdata;
  } pcs_req_s;

  typedef struct packed {
    logic         inject;
    logic         single;
  } pcs_inj_s;

endpackage : pcs_pkg

// ---- design/pcs_divider.sv ----
// Oscillator divider producing the divide-by-2 or divide-by-4 output clock
`timescale 1ns/100ps
`default_nettype none
module pcs_divider
  import pcs_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_arst_n,
  input  wire logic i_ce,
  input  wire logic i_en,
  input  wire logic i_div4,
  output logic      o_clk
);

  logic [1:0] cnt_r;

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      cnt_r <= 2'h0;
    else if (i_ce)
    begin
      if (!i_en)
        cnt_r <= 2'h0;
      else
        cnt_r <= cnt_r + 2'h1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_clk <= 1'b0;
    else if (i_ce)
      o_clk <= i_en & (i_div4 ? cnt_r[1] : cnt_r[0]);
  end

endmodule : pcs_divider
`default_nettype wire

// ---- design/pcs_regs.sv ----
// Register bank: oscillator divider, self-test CRC count, error injection, PLL reference override
`timescale 1ns/100ps
`default_nettype none
module pcs_regs
  import pcs_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  input  wire logic        i_ce,
  input  wire pcs_req_s    i_req,
  output logic [7:0]       o_rdata,
  input  wire logic        i_strap_ext_osc,
  input  wire logic        i_pll_source_override,
  input  wire logic        i_selftest_active,
  input  wire logic        i_bc_crc_error,
  input  wire logic        i_frame_slot,
  output pcs_inj_s         o_inj,
  output logic             o_general_output_two,
  output pcs_src_e         o_pll_src
);

  logic [1:0] osc_rsvd_hi_r;
  logic [4:0] osc_rsvd_lo_r;
  logic       osc_div_r;
  logic [7:0] crc_cnt_r;
  logic       force_one_r;
  logic [6:0] st_errs_r;
  logic [6:0] st_left_r;
  logic [3:0] ovr_rsvd_r;
  logic       ext_lock_r;
  logic       int_osc_r;
  logic       strap_m_r;
  logic       strap_r;
  logic       st_act_q_r;
  logic       st_start;
  logic       wr_osc;
  logic       wr_inj;
  logic       wr_ovr;
  logic       single_go;
  logic       multi_go;
  logic [7:0] rdata_nxt;

  // Writes elsewhere, and to read-only bits, are dropped
  assign wr_osc   = i_req.wr && (i_req.addr == PCS_OFF_OSC_DIV);
  assign wr_inj   = i_req.wr && (i_req.addr == PCS_OFF_FWD_INJ);
  assign wr_ovr   = i_req.wr && (i_req.addr == PCS_OFF_PLL_OVR);
  assign st_start = i_selftest_active && !st_act_q_r;

  // Strap pin is asynchronous to the register clock
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      strap_m_r <= 1'b0;
      strap_r   <= 1'b0;
    end
    else if (i_ce)
    begin
      strap_m_r <= i_strap_ext_osc;
      strap_r   <= strap_m_r;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      osc_rsvd_hi_r <= PCS_RST_OSC_RSVD_HI;
      osc_div_r     <= PCS_RST_OSC_DIV;
      osc_rsvd_lo_r <= PCS_RST_OSC_RSVD_LO;
    end
    else if (i_ce && wr_osc)
    begin
      osc_rsvd_hi_r <= i_req.wdata[7:6];
      osc_div_r     <= i_req.wdata[PCS_BIT_OSC_DIV];
      osc_rsvd_lo_r <= i_req.wdata[4:0];
    end
  end

  // Counter saturates rather than wrapping so a long test never hides errors
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      crc_cnt_r <= PCS_RST_CRC_CNT;
    else if (i_ce)
    begin
      if (st_start)
        crc_cnt_r <= PCS_RST_CRC_CNT;
      else if (i_selftest_active && i_bc_crc_error && crc_cnt_r != PCS_CRC_CNT_MAX)
        crc_cnt_r <= crc_cnt_r + 8'h01;
    end
  end

  assign single_go = force_one_r && !i_selftest_active && i_frame_slot;
  assign multi_go  = i_selftest_active && !st_start && (st_left_r != 7'h00) && i_frame_slot;

  // A pending single error is kept while self-test runs and fires after it
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      force_one_r <= 1'b0;
    else if (i_ce)
    begin
      if (wr_inj && i_req.wdata[PCS_BIT_FORCE_ONE])
        force_one_r <= 1'b1;
      else if (single_go)
        force_one_r <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      st_errs_r <= PCS_RST_ST_ERRS;
    else if (i_ce && wr_inj)
      st_errs_r <= i_req.wdata[6:0];
  end

  // Budget is latched at self-test start; later writes wait for the next run
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_left_r  <= 7'h00;
      st_act_q_r <= 1'b0;
    end
    else if (i_ce)
    begin
      st_act_q_r <= i_selftest_active;
      if (st_start)
        st_left_r <= st_errs_r;
      else if (!i_selftest_active)
        st_left_r <= 7'h00;
      else if (multi_go)
        st_left_r <= st_left_r - 7'h01;
    end
  end

  // Single flag lets the link tell the forced error apart
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_inj <= '0;
    else if (i_ce)
    begin
      o_inj.inject <= single_go || multi_go;
      o_inj.single <= single_go;
    end
  end

  // Reserved bits 7:4 are kept so software reads back its writes; bit 2 is not stored and reads zero
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ovr_rsvd_r <= PCS_RST_OVR_RSVD;
      ext_lock_r <= PCS_RST_EXT_LOCK;
      int_osc_r  <= PCS_RST_INT_OSC;
    end
    else if (i_ce && wr_ovr)
    begin
      ovr_rsvd_r <= i_req.wdata[7:4];
      ext_lock_r <= i_req.wdata[PCS_BIT_EXT_LOCK];
      int_osc_r  <= i_req.wdata[PCS_BIT_INT_OSC];
    end
  end

  // Without override the strap decides between external clock and pixel clock
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_pll_src <= PCS_SRC_PCLK;
    else if (i_ce)
    begin
      if (i_pll_source_override)
      begin
        if (int_osc_r)
          o_pll_src <= PCS_SRC_OSC;
        else if (ext_lock_r)
          o_pll_src <= PCS_SRC_EXT;
        else
          o_pll_src <= PCS_SRC_PCLK;
      end
      else
        o_pll_src <= strap_r ? PCS_SRC_EXT : PCS_SRC_PCLK;
    end
  end

  // Divider only runs while the strap selects the oscillator
  pcs_divider u_div (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_ce     (i_ce),
    .i_en     (strap_r),
    .i_div4   (osc_div_r),
    .o_clk    (o_general_output_two)
  );

  // Unmapped and reserved offsets read as zero
  always_comb
  begin
    rdata_nxt = 8'h00;
    case (i_req.addr)
      PCS_OFF_OSC_DIV: rdata_nxt = {osc_rsvd_hi_r, osc_div_r, osc_rsvd_lo_r};
      PCS_OFF_CRC_CNT: rdata_nxt = crc_cnt_r;
      PCS_OFF_FWD_INJ: rdata_nxt = {force_one_r, st_errs_r};
      PCS_OFF_PLL_OVR: rdata_nxt = {ovr_rsvd_r, strap_r, 1'b0, ext_lock_r, int_osc_r};
      default:         rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_rdata <= 8'h00;
    else if (i_ce && i_req.rd)
      o_rdata <= rdata_nxt;
  end

endmodule : pcs_regs
`default_nettype wire

// ---- testbench/pcs_monitor.sv ----
// Port checker for the clock select and error inject registers
`timescale 1ns/100ps
`default_nettype none
module pcs_monitor
  import pcs_pkg::*;
(
  input wire logic       i_mclk,
  input wire logic       i_arst_n,
  input wire pcs_req_s   i_req,
  input wire logic       i_strap_ext_osc,
  input wire logic       i_pll_source_override,
  input wire logic       i_selftest_active,
  input wire logic       i_frame_slot,
  input wire logic [7:0] o_rdata,
  input wire pcs_inj_s   o_inj,
  input wire logic       o_general_output_two,
  input wire pcs_src_e   o_pll_src
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  a_single_has_inject: assert property (o_inj.single |-> o_inj.inject) else $error("lone single flag");
  a_single_outside_st: assert property (o_inj.single |-> !$past(i_selftest_active)) else $error("single in test");
  a_inject_after_slot: assert property (o_inj.inject |-> $past(i_frame_slot)) else $error("inject off slot");
  a_st_inject_active: assert property (o_inj.inject && !o_inj.single |-> $past(i_selftest_active))
    else $error("test inject idle");
  a_gpo_quiet_nostrap: assert property ((!i_strap_ext_osc)[*5] |-> !o_general_output_two)
    else $error("divider runs");
  a_src_pclk_default: assert property ((!i_pll_source_override && !i_strap_ext_osc)[*5] |->
    o_pll_src == PCS_SRC_PCLK) else $error("bad source");
  a_rdata_holds: assert property (!$past(i_req.rd) |-> $stable(o_rdata)) else $error("rdata moved");
  a_reserved_reads_zero: assert property ($past(i_req.rd && i_req.addr == 8'h28) |-> o_rdata == 8'h00)
    else $error("reserved nonzero");
  c_single: cover property (o_inj.single);
  c_st_inject: cover property (o_inj.inject && !o_inj.single);
  c_gpo: cover property (o_general_output_two);
endmodule : pcs_monitor
bind pcs_regs pcs_monitor pcs_monitor_i (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_req(i_req),
  .i_strap_ext_osc(i_strap_ext_osc), .i_pll_source_override(i_pll_source_override),
  .i_selftest_active(i_selftest_active), .i_frame_slot(i_frame_slot), .o_rdata(o_rdata), .o_inj(o_inj),
  .o_general_output_two(o_general_output_two), .o_pll_src(o_pll_src));
`default_nettype wire

// ---- testbench/pcs_host.sv ----
// Host model issuing single-byte management requests
`timescale 1ns/100ps
`default_nettype none
module pcs_host
  import pcs_pkg::*;
(
  input  wire logic   i_mclk,
  output var pcs_req_s o_req
);
  initial o_req = '0;
  // Gap cycle so a new request never lands in the clearing time step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    o_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge i_mclk);
    #1 o_req = '0;
    @(posedge i_mclk);
    #1;
  endtask : xfer
endmodule : pcs_host
`default_nettype wire

// ---- testbench/tb_pcs_regs.sv ----
// Testbench for the clock select and error inject registers
`timescale 1ns/100ps
`default_nettype none
module tb_pcs_regs
  import pcs_pkg::*;
;
  logic clk = 0, arst_n = 0, ce = 1, strap = 0, ovr = 0, st = 0, crc = 0, fs = 0, r;
  logic [7:0] rdata, v, exp_q[$];
  logic [7:0] ra[5] = '{8'h28, 8'h29, 8'h2a, 8'h2d, 8'h35};
  logic [7:0] re[5] = '{8'h00, 8'h06, 8'h00, 8'h00, 8'h01};
  logic [7:0] pw[3] = '{8'h01, 8'h02, 8'h00};
  pcs_src_e ps[3] = '{PCS_SRC_OSC, PCS_SRC_EXT, PCS_SRC_PCLK};
  pcs_req_s req;
  pcs_inj_s inj;
  pcs_src_e src;
  logic general_output_two;
  int mismatches = 0, samples_checked = 0, ninj = 0, nsgl = 0, c, seed = 32'hf877;
  initial forever #2 clk = ~clk;
  pcs_host pcs_host_i (.i_mclk(clk), .o_req(req));
  pcs_regs pcs_regs_i (.i_mclk(clk), .i_arst_n(arst_n), .i_ce(ce), .i_req(req), .o_rdata(rdata),
    .i_strap_ext_osc(strap), .i_pll_source_override(ovr), .i_selftest_active(st), .i_bc_crc_error(crc),
    .i_frame_slot(fs), .o_inj(inj), .o_general_output_two(general_output_two), .o_pll_src(src));
  task check(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask : check
  task rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    pcs_host_i.xfer(1'b0, a, 8'h00);
  endtask : rd
  task automatic pulse(ref logic p, input int n);
    repeat (n)
    begin
      p = 1;
      @(posedge clk);
      #1 p = 0;
      @(posedge clk);
      #1;
    end
  endtask : pulse
  task automatic toggles(output int n);
    logic p;
    n = 0;
    repeat (8)
    begin
      p = general_output_two;
      @(posedge clk);
      #1 n += int'(general_output_two !== p);
    end
  endtask : toggles
  task print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // Read data is registered on the same edge that takes the request
  always @(posedge clk)
  begin
    r = req.rd;
    #1;
    if (r === 1'b1)
      check(rdata, exp_q.pop_front());
  end
  always @(posedge clk)
    if (inj.inject === 1'b1)
    begin
      ninj++;
      nsgl += int'(inj.single);
    end
  initial
  begin
    #20000 mismatches++;
    print_verdict;
  end
  initial
  begin
    repeat (20) @(posedge clk);
    #1 arst_n = 1;
    @(posedge clk);
    #1;
    foreach (ra[i]) rd(ra[i], re[i]);
    v = 8'($random(seed));
    pcs_host_i.xfer(1'b1, 8'h29, v);
    rd(8'h29, v);
    ce = 0;
    pcs_host_i.xfer(1'b1, 8'h29, ~v);
    ce = 1;
    rd(8'h29, v);
    strap = 1;
    pcs_host_i.xfer(1'b1, 8'h29, 8'h00);
    // Strap synchroniser and divider need two more edges to settle
    repeat (2) @(posedge clk);
    #1;
    toggles(c);
    check(8'(c), 8'h08);
    pcs_host_i.xfer(1'b1, 8'h29, 8'h20);
    toggles(c);
    check(8'(c), 8'h04);
    rd(8'h35, 8'h09);
    $display("divider and status done");
    ovr = 1;
    foreach (pw[i])
    begin
      pcs_host_i.xfer(1'b1, 8'h35, pw[i]);
      check({6'h00, src}, {6'h00, ps[i]});
    end
    $display("source select done");
    pcs_host_i.xfer(1'b1, 8'h2d, 8'h80);
    pulse(fs, 3);
    check(8'(nsgl), 8'h01);
    check(8'(ninj), 8'h01);
    rd(8'h2d, 8'h00);
    $display("single inject done");
    pcs_host_i.xfer(1'b1, 8'h2d, 8'h03);
    st = 1;
    @(posedge clk);
    #1;
    pulse(crc, 2);
    pulse(fs, 5);
    st = 0;
    check(8'(ninj), 8'h04);
    rd(8'h2a, 8'h02);
    $display("self-test inject done");
    print_verdict;
  end
endmodule : tb_pcs_regs
`default_nettype wire
